// *** bench/test_wdt_supervisor.sv ***
// Self-checking bench for the watchdog supervisor.
// Drives the register port directly; full periods are too long to run.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("mismatch %0t got %h exp %h", $time, a, b); end end
module test_wdt_supervisor;
   import wdt_pkg::*;
   logic            sys_clk_in    = 1'b0;
   logic            reset_in      = 1'b1;
   wdt_sfr_req_type sfr_req_in    = '0;
   logic            supply_irq_in = 1'b0;
   logic [7:0]      sfr_rdata_out;
   logic            system_reset_out;
   logic            wdt_irq_out;
   logic            wdt_irq_high_prio_out;
   int              pulses     = 0;
   int              fail_count = 0;
   int              n_checks   = 0;
   int              cycles     = 0;
   wdt_supervisor dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .sfr_req_in(sfr_req_in),
      .sfr_rdata_out(sfr_rdata_out), .supply_irq_in(supply_irq_in),
      .system_reset_out(system_reset_out), .wdt_irq_out(wdt_irq_out),
      .wdt_irq_high_prio_out(wdt_irq_high_prio_out));
   initial begin
      forever #20 sys_clk_in = ~sys_clk_in;
   end
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic instr(input logic wr, input logic bw, input logic [7:0] d);
      @(posedge sys_clk_in);
      sfr_req_in <= '{wr, bw, 3'h0, bw, WDT_CONTROL_ADDR, d, 1'b0};
      @(posedge sys_clk_in);
      sfr_req_in <= '{instr_done: 1'b1, default: '0};
      @(posedge sys_clk_in);
      sfr_req_in <= '0;
   endtask
   task automatic wr_ctl(input logic [7:0] d);
      instr(1'b1, 1'b1, 8'h00);
      instr(1'b1, 1'b0, d);
   endtask
   task automatic watch(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   // Counts every cycle in which a reset or interrupt request stands
   always @(negedge sys_clk_in) begin
      if ((system_reset_out | wdt_irq_out) !== 1'b0) begin
         pulses <= pulses + 1;
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         end_sim();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      watch(2);
      `CHK(sfr_rdata_out, WDT_CONTROL_RESET)
      instr(1'b1, 1'b0, 8'h72);
      watch(2);
      `CHK(sfr_rdata_out, 8'h10)
      wr_ctl(8'h72);
      watch(2);
      `CHK(sfr_rdata_out, 8'h72)
      instr(1'b1, 1'b1, 8'h00);
      instr(1'b0, 1'b0, 8'h00);
      instr(1'b1, 1'b0, 8'h10);
      watch(2);
      `CHK(sfr_rdata_out, 8'h72)
      $display("test unlock done");
      @(posedge sys_clk_in);
      supply_irq_in <= 1'b1;
      @(posedge sys_clk_in);
      supply_irq_in <= 1'b0;
      watch(3);
      `CHK(sfr_rdata_out, 8'h70)
      $display("test supply done");
      wr_ctl(8'h8A);
      watch(12);
      `CHK(pulses, 0)
      wr_ctl(8'h80);
      watch(12);
      `CHK(pulses, 0)
      wr_ctl(8'h82);
      watch(12);
      `CHK(pulses, 1)
      `CHK(sfr_rdata_out[1], 1'b0)
      $display("test prescale done");
      wr_ctl(8'h14);
      watch(2);
      `CHK(sfr_rdata_out, 8'h14)
      wr_ctl(8'h10);
      watch(2);
      `CHK(sfr_rdata_out, 8'h10)
      wr_ctl(8'h14);
      @(posedge sys_clk_in);
      reset_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      watch(2);
      `CHK(sfr_rdata_out, WDT_CONTROL_RESET)
      `CHK(pulses, 1)
      $display("test flag done");
      end_sim();
   end
endmodule
bind wdt_supervisor wdt_supervisor_sva u_sva (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
   .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out), .supply_irq_in(supply_irq_in),
   .system_reset_out(system_reset_out), .wdt_irq_out(wdt_irq_out),
   .wdt_irq_high_prio_out(wdt_irq_high_prio_out));
`default_nettype wire

// *** bench/wdt_supervisor_sva.sv ***
// Port-level assertions for the watchdog supervisor.
// Sees only the top module's ports; bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module wdt_supervisor_sva
   import wdt_pkg::*;
(
   // Clock and reset
   input wire logic            sys_clk_in,
   input wire logic            reset_in,
   // Watched ports
   input wire wdt_sfr_req_type sfr_req_in,
   input wire logic [7:0]      sfr_rdata_out,
   input wire logic            supply_irq_in,
   input wire logic            system_reset_out,
   input wire logic            wdt_irq_out,
   input wire logic            wdt_irq_high_prio_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   a_reset_value: assert property ($fell(reset_in) |-> sfr_rdata_out == 8'h10)
      else $error("control not 10H after reset");
   a_unlock_reads_zero: assert property (sfr_rdata_out[0] == 1'b0)
      else $error("unlock bit reads set");
   a_prio_matches_irq: assert property (wdt_irq_out == wdt_irq_high_prio_out)
      else $error("priority flag differs from irq");
   a_reset_not_irq: assert property (!(system_reset_out && wdt_irq_out))
      else $error("reset and irq together");
   a_reset_sel_clear: assert property (system_reset_out |-> !sfr_rdata_out[3])
      else $error("reset with irq select set");
   a_reset_when_armed: assert property (system_reset_out |-> sfr_rdata_out[1] || $past(sfr_rdata_out[1]))
      else $error("reset while disarmed");
   a_irq_flag_sel: assert property (wdt_irq_out |-> sfr_rdata_out[3] ##1 sfr_rdata_out[2])
      else $error("irq without flag or select");
   a_irq_one_cycle: assert property (wdt_irq_out |=> !wdt_irq_out)
      else $error("irq longer than one cycle");
   a_supply_disarms: assert property (supply_irq_in |-> ##2 !sfr_rdata_out[1])
      else $error("supply irq left arm set");
   c_reset: cover property (system_reset_out);
   c_supply: cover property (supply_irq_in);
   c_bit_write: cover property (sfr_req_in.write && sfr_req_in.bit_write);
endmodule
`default_nettype wire

// *** core/wdt_pkg.sv ***
// Constants and types for the watchdog supervisor.
// Assumes a core-side special-function register port on sys_clk_in.
//
// How it works
// - Armed watchdog expiring unrefreshed sets timeout flag and raises reset or interrupt.
// - Arm bit written zero stops the watchdog; no reset or interrupt follows.
// - Period timed by a 16-bit counter advanced by the 32 kHz RC tick.
// - Timeout equals two to the prescale code times 2^9 RC periods.
// - Prescale codes 0 to 7 select periods; code 8 forces immediate reset when armed with interrupt-select clear.
// - Every control write needs unlock bit set, then the write next instruction.
// - Control register at address C0H, bit-addressable, resets to 10H.
// - Interrupt-select set gives interrupt on expiry, clear gives system reset.
// - Watchdog interrupt bypasses global mask at fixed high priority.
// - Timeout flag sets on expiry, clears on zero write or external reset.
// - Arm bit set restarts counters; clears on zero write, dog reset, reset, supply irq.
package wdt_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] WDT_CONTROL_ADDR  = 8'hC0;
   localparam logic [7:0] WDT_CONTROL_RESET = 8'h10;
   localparam int         WDT_BIT_UNLOCK    = 0;
   localparam int         WDT_BIT_ARM       = 1;
   localparam int         WDT_BIT_FLAG      = 2;
   localparam int         WDT_BIT_IRQSEL    = 3;
   localparam int         WDT_PRE_LSB       = 4;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int         WDT_CNT_WIDTH     = 16;
   localparam int         WDT_BASE_LOG2     = 9;
   localparam int         WDT_PRE_MAX       = 7;
   localparam logic [3:0] WDT_PRE_IMMEDIATE = 4'h8;
   localparam int         WDT_CLK_HZ        = 25000000;
   localparam int         WDT_RC_HZ         = 32000;
   // Cycles of sys_clk_in per RC tick, rounded down
   localparam int         WDT_RC_DIV        = WDT_CLK_HZ / WDT_RC_HZ;
   localparam int         WDT_DIV_WIDTH     = 10;

   // ----------------------------------------
   // Special-function register access
   // ----------------------------------------
   typedef struct packed {
      logic       write;
      logic       bit_write;
      logic [2:0] bit_index;
      logic       bit_value;
      logic [7:0] address;
      logic [7:0] data;
      logic       instr_done;
   } wdt_sfr_req_type;

   typedef struct packed {
      logic [3:0] prescale;
      logic       irq_select;
      logic       timeout_flag;
      logic       arm;
      logic       unlock;
   } wdt_control_type;

endpackage

// *** core/wdt_rc_tick.sv ***
// RC oscillator tick model: divides sys_clk_in to a 32 kHz enable pulse.
// Assumes sys_clk_in at 25 MHz and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module wdt_rc_tick
   import wdt_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic reset_in,
   input  wire logic restart_in,
   // Tick
   output logic      tick_out
);
   localparam logic [WDT_DIV_WIDTH-1:0] DIV_LAST = WDT_DIV_WIDTH'(WDT_RC_DIV - 1);
   logic [WDT_DIV_WIDTH-1:0] div_count;

   always_ff @(posedge sys_clk_in) begin
      if (reset_in || restart_in) begin
         div_count <= '0;
         tick_out  <= 1'b0;
      end else if (div_count == DIV_LAST) begin
         div_count <= '0;
         tick_out  <= 1'b1;
      end else begin
         div_count <= div_count + 1'b1;
         tick_out  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** core/wdt_supervisor.sv ***
// Watchdog supervisor with its control special-function register.
// Assumes the core presents one SFR request per cycle and marks instruction ends.
`timescale 1ns/1ps
`default_nettype none
module wdt_supervisor
   import wdt_pkg::*;
(
   // Clock and reset
   input  wire logic            sys_clk_in,
   input  wire logic            reset_in,
   // Core register port
   input  wire wdt_sfr_req_type sfr_req_in,
   output logic [7:0]           sfr_rdata_out,
   // Supply monitor
   input  wire logic            supply_irq_in,
   // Watchdog actions
   output logic                 system_reset_out,
   output logic                 wdt_irq_out,
   output logic                 wdt_irq_high_prio_out
);
   typedef enum logic [1:0] {
      WDT_IDLE,
      WDT_UNLOCKED,
      WDT_LAPSE
   } wdt_unlock_state_type;

   localparam int                   PRE_WIDTH  = $bits(wdt_control_type) - WDT_PRE_LSB;
   localparam logic [PRE_WIDTH-1:0] PRE_LAST   = PRE_WIDTH'(WDT_PRE_MAX);
   localparam wdt_control_type      CTRL_RESET = wdt_control_type'(WDT_CONTROL_RESET);

   wdt_control_type          ctrl;
   wdt_unlock_state_type     unlock_state;
   logic [PRE_WIDTH-1:0]     timeout_prescale_field;
   logic                     watchdog_irq_select;
   logic                     watchdog_timeout_flag;
   logic                     watchdog_arm_bit;
   logic [WDT_CNT_WIDTH-1:0] wd_count;
   logic [WDT_CNT_WIDTH-1:0] period_limit;
   logic                     period_valid;
   logic                     immediate;
   logic                     rc_tick;
   logic                     restart;
   logic                     addr_hit;
   logic                     unlock_hit;
   logic                     ctrl_write;
   logic                     expire;
   logic [7:0]               next_value;
   logic                     dog_reset;
   logic                     dog_irq;
   logic                     disarm;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic [WDT_CNT_WIDTH-1:0] wdt_limit(input logic [3:0] pre);
      logic [WDT_CNT_WIDTH:0] full;
      full = (WDT_CNT_WIDTH+1)'(1) << (WDT_BASE_LOG2 + int'(pre[2:0]));
      wdt_limit = WDT_CNT_WIDTH'(full - 1'b1);
   endfunction

   function automatic logic [7:0] wdt_merge(input wdt_sfr_req_type r, input logic [7:0] cur);
      logic [7:0] v;
      v = cur;
      if (r.bit_write) begin
         v[r.bit_index] = r.bit_value;
      end else begin
         v = r.data;
      end
      wdt_merge = v;
   endfunction

   // ----------------------------------------
   // Register port decode
   // ----------------------------------------
   assign addr_hit   = sfr_req_in.write && (sfr_req_in.address == WDT_CONTROL_ADDR);
   assign next_value = wdt_merge(sfr_req_in, ctrl);
   assign unlock_hit = addr_hit && next_value[WDT_BIT_UNLOCK];
   // Locked writes may only set the unlock bit
   assign ctrl_write = addr_hit && (unlock_state == WDT_UNLOCKED);
   assign restart    = ctrl_write && next_value[WDT_BIT_ARM];

   // ----------------------------------------
   // Period decode and actions
   // ----------------------------------------
   assign period_limit = wdt_limit(timeout_prescale_field);
   assign period_valid = (timeout_prescale_field <= PRE_LAST);
   assign immediate    = (timeout_prescale_field == WDT_PRE_IMMEDIATE);
   assign expire       = watchdog_arm_bit && period_valid && rc_tick
                         && (wd_count == period_limit);
   assign dog_reset    = watchdog_arm_bit && !watchdog_irq_select
                         && (expire || immediate);
   assign dog_irq      = expire && watchdog_irq_select;
   assign disarm       = dog_reset || supply_irq_in;

   // ----------------------------------------
   // Register image, unlock bit always reads zero
   // ----------------------------------------
   assign ctrl = '{prescale:     timeout_prescale_field,
                   irq_select:   watchdog_irq_select,
                   timeout_flag: watchdog_timeout_flag,
                   arm:          watchdog_arm_bit,
                   unlock:       1'b0};

   // ----------------------------------------
   // RC oscillator timebase
   // ----------------------------------------
   wdt_rc_tick u_rc_tick (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .restart_in (restart),
      .tick_out   (rc_tick)
   );

   // ----------------------------------------
   // Unlock sequence
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         unlock_state <= WDT_IDLE;
      end else begin
         unique case (unlock_state)
            WDT_IDLE: begin
               if (unlock_hit) begin
                  unlock_state <= WDT_LAPSE;
               end
            end
            WDT_LAPSE: begin
               // Wait for the unlocking instruction to finish
               if (sfr_req_in.instr_done) begin
                  unlock_state <= WDT_UNLOCKED;
               end
            end
            WDT_UNLOCKED: begin
               if (ctrl_write || sfr_req_in.instr_done) begin
                  unlock_state <= WDT_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         timeout_prescale_field <= CTRL_RESET.prescale;
         watchdog_irq_select    <= CTRL_RESET.irq_select;
      end else if (ctrl_write) begin
         timeout_prescale_field <= next_value[WDT_PRE_LSB +: PRE_WIDTH];
         watchdog_irq_select    <= next_value[WDT_BIT_IRQSEL];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         watchdog_arm_bit <= CTRL_RESET.arm;
      end else if (disarm) begin
         watchdog_arm_bit <= 1'b0;
      end else if (ctrl_write) begin
         watchdog_arm_bit <= next_value[WDT_BIT_ARM];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         watchdog_timeout_flag <= CTRL_RESET.timeout_flag;
      end else if (expire) begin
         // Expiry in the same cycle wins over a zero write
         watchdog_timeout_flag <= 1'b1;
      end else if (ctrl_write) begin
         watchdog_timeout_flag <= next_value[WDT_BIT_FLAG];
      end
   end

   // ----------------------------------------
   // Period counter on the RC tick
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || restart || !watchdog_arm_bit || expire) begin
         wd_count <= '0;
      end else if (rc_tick) begin
         wd_count <= wd_count + 1'b1;
      end
   end

   // ----------------------------------------
   // System reset request
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         system_reset_out <= 1'b0;
      end else begin
         system_reset_out <= dog_reset;
      end
   end

   // ----------------------------------------
   // Interrupt request, never masked
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         wdt_irq_out           <= 1'b0;
         wdt_irq_high_prio_out <= 1'b0;
      end else begin
         wdt_irq_out           <= dog_irq;
         wdt_irq_high_prio_out <= dog_irq;
      end
   end

   // ----------------------------------------
   // Register read-back
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         sfr_rdata_out <= WDT_CONTROL_RESET;
      end else begin
         sfr_rdata_out <= ctrl;
      end
   end
endmodule
`default_nettype wire
